// ===== rtl/vac_control_regs.sv
`default_nettype none
// What this block does
// R1: Output data valid within 10 ms of change
// R2: Host releases soft reset before other writes
// R3: Unused register bits accepted and ignored
// R4: Soft reset zero forces other registers initial
// R5: Soft reset zero discards other register writes
// R6: Host writes zero to reserved bits
// R7: Control bit 5 selects double lane drive
// R8: Control bit 4 selects correlated sampling mode
// R9: Control bits 3:2 place feed-through pulse
// R10: Feed-through pulse fixed width, correlated mode only
// R11: Control bit 1 selects double-edge clock mode
// R12: Power-down halts all but serial writes
// R13: Register contents survive power-down unchanged
// R14: Offset code resets to 128, zero offset
// R15: Gain code resets to zero, unity gain
// R16: Sampling bit 5 selects external trigger source
// R17: Sampling bits 4:3 set data pulse width
// R18: Width ignored when external trigger selected
// R19: Sampling bit 0 selects split output order
// R20: Frame: five zeros, address, data, MSB first
// R21: Last sixteen edges count; fewer is invalid
// R22: Enable low releases lanes to serial inputs
// R23: Commit on enable rise after full frame
// R24: Settings reach master logic through synchronisers
module vac_control_regs #(
	parameter int SETTLE_CYCLES = vac_pkg::SETTLE_CYCLES
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic laneZeroIn,
	input wire logic laneOneIn,
	input wire logic serialEnableLow,
	input wire logic sampleTriggerIn,
	input wire logic [15:0] convData,
	output logic laneZeroOut,
	output logic laneOneOut,
	output logic laneOe,
	output logic dataLevelSamplePulse,
	output logic feedthroughSamplePulse,
	output logic driveDouble,
	output logic correlatedSamplingMode,
	output logic doubleEdgeMode,
	output logic powerUp,
	output logic [7:0] offsetDacCode,
	output logic [5:0] gainCode,
	output logic dataValid
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] pinSync;
	logic sclkSync;
	logic sdataSync;
	logic enLowSync;
	logic trigSync;

	vac_sync #(
		.WIDTH(4),
		.RESET_VAL(4'h2)
	) pinSyncInst ( // R24
		.mclk(mclk),
		.rstn(rstn),
		.asyncIn({sampleTriggerIn, laneOneIn, serialEnableLow, laneZeroIn}),
		.syncOut(pinSync)
	);

	assign sclkSync = pinSync[0];
	assign enLowSync = pinSync[1];
	assign sdataSync = pinSync[2];
	assign trigSync = pinSync[3];

	vac_pkg::vac_state_t q;
	vac_pkg::vac_state_t d;

	logic sclkRise;
	logic enRise;
	logic commit;
	logic [2:0] wrAddr;
	logic [7:0] wrData;
	logic [2:0] nextSlot;
	logic [1:0] widthCode;
	logic [1:0] posCode;

	function automatic logic [1:0] laneBits(input logic [15:0] word, input logic [2:0] slot,
		input logic split);
		logic [15:0] sh;
		sh = 16'h0000;
		if (split) begin
			sh = word << slot;
			laneBits = {sh[15], sh[7]};
		end else begin
			sh = word << {slot, 1'b0};
			laneBits = {sh[15], sh[14]};
		end
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		sclkRise = sclkSync && !q.sclkPrev && !q.laneOe && (q.turnCnt == 2'h0); // R22
		enRise = enLowSync && !q.enPrev;
		commit = enRise && (q.bitCnt == vac_pkg::FRAME_BITS); // R23 R21
		wrAddr = q.shift[vac_pkg::FRAME_ADDR_LSB +: 3]; // R20
		wrData = q.shift[7:0];
		d.sclkPrev = sclkSync;
		d.enPrev = enLowSync;

		// The synced pin still shows our own lane data for a few cycles after
		// release; holding the edge detector high stops that tail faking a clock
		if (q.laneOe) begin
			d.turnCnt = vac_pkg::TURN_CYCLES;
		end else if (q.turnCnt != 2'h0) begin
			d.turnCnt = q.turnCnt - 2'h1;
		end
		if (q.laneOe || (q.turnCnt != 2'h0)) begin
			d.sclkPrev = 1'b1; // R22
		end

		// Serial write front end keeps running in power-down
		if (!enLowSync) begin
			if (sclkRise) begin
				d.shift = {q.shift[14:0], sdataSync}; // R20 R21
				if (q.bitCnt != vac_pkg::FRAME_BITS) begin
					d.bitCnt = q.bitCnt + 5'h01;
				end
			end
		end else begin
			d.bitCnt = 5'h00;
		end

		if (commit) begin
			case (wrAddr)
				vac_pkg::ADDR_OPERATING_CONTROL: begin
					if (q.regs.ctl[vac_pkg::CTL_SOFT_RESET]) begin
						d.regs.ctl = wrData & vac_pkg::CTL_WRITE_MASK; // R3
					end else begin
						d.regs.ctl[vac_pkg::CTL_SOFT_RESET] = wrData[vac_pkg::CTL_SOFT_RESET]; // R5
					end
				end
				vac_pkg::ADDR_OFFSET_DAC_CODE: begin
					if (q.regs.ctl[vac_pkg::CTL_SOFT_RESET]) begin
						d.regs.ofs = wrData; // R5 R14
					end
				end
				vac_pkg::ADDR_GAIN_CODE: begin
					if (q.regs.ctl[vac_pkg::CTL_SOFT_RESET]) begin
						d.regs.gain = wrData[5:0]; // R3 R15
					end
				end
				vac_pkg::ADDR_SAMPLING_OUTPUT_CONTROL: begin
					if (q.regs.ctl[vac_pkg::CTL_SOFT_RESET]) begin
						d.regs.smp = wrData & vac_pkg::SMP_WRITE_MASK; // R3
					end
				end
				default: begin
					// Test addresses and unmapped codes take no effect
				end
			endcase
		end

		// Forcing applies every cycle the bit is low, not only on writes
		if (!d.regs.ctl[vac_pkg::CTL_SOFT_RESET]) begin
			d.regs.ctl = vac_pkg::RST_OPERATING_CONTROL; // R4
			d.regs.ofs = vac_pkg::RST_OFFSET_DAC_CODE;
			d.regs.gain = vac_pkg::RST_GAIN_CODE;
			d.regs.smp = vac_pkg::RST_SAMPLING_OUTPUT_CONTROL;
		end

		// Lanes turn round to serial inputs whenever enable is low
		d.laneOe = enLowSync; // R22

		nextSlot = 3'h0;
		widthCode = q.regs.smp[vac_pkg::SMP_WIDTH_LSB +: 2];
		posCode = q.regs.ctl[vac_pkg::CTL_FEED_POS_LSB +: 2];
		if (q.regs.ctl[vac_pkg::CTL_POWER_UP]) begin
			nextSlot = q.slot + 3'h1;
			d.slot = nextSlot;
			if (q.slot == vac_pkg::LAST_SLOT) begin
				d.capture = convData;
			end
			// One slot is one master period, in single-edge and double-edge mode alike
			if (q.regs.smp[vac_pkg::SMP_SOURCE_EXT]) begin
				d.dataPulse = trigSync; // R16 R18
			end else begin
				d.dataPulse = (nextSlot >= (vac_pkg::LAST_SLOT - {1'b0, widthCode})); // R17
			end
			d.feedPulse = q.regs.ctl[vac_pkg::CTL_INPUT_MODE]
				&& (nextSlot == (vac_pkg::FEED_BASE_SLOT + {1'b0, posCode})); // R9 R10
			d.lane = laneBits((q.slot == vac_pkg::LAST_SLOT) ? convData : q.capture,
				nextSlot, q.regs.smp[vac_pkg::SMP_SPLIT_ORDER]); // R19
			if (d.regs != q.regs) begin
				d.settle = SETTLE_CYCLES[vac_pkg::SETTLE_W-1:0]; // R1
			end else if (q.settle != '0) begin
				d.settle = q.settle - 1'b1;
			end
			d.valid = (d.settle == '0);
		end else begin
			// Power-down holds the pixel logic at slot 0 with pulses, lanes and valid low; registers are untouched
			d.slot = 3'h0; // R12 R13
			d.dataPulse = 1'b0;
			d.feedPulse = 1'b0;
			d.lane = 2'h0;
			d.valid = 1'b0;
			if (d.regs != q.regs) begin
				d.settle = SETTLE_CYCLES[vac_pkg::SETTLE_W-1:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			q <= '0;
			q.regs.ofs <= vac_pkg::RST_OFFSET_DAC_CODE;
			q.enPrev <= 1'b1;
			q.laneOe <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign laneZeroOut = q.lane[0];
	assign laneOneOut = q.lane[1];
	assign laneOe = q.laneOe;
	assign dataLevelSamplePulse = q.dataPulse;
	assign feedthroughSamplePulse = q.feedPulse;
	assign driveDouble = q.regs.ctl[vac_pkg::CTL_DRIVE_DOUBLE]; // R7
	assign correlatedSamplingMode = q.regs.ctl[vac_pkg::CTL_INPUT_MODE]; // R8
	assign doubleEdgeMode = q.regs.ctl[vac_pkg::CTL_CLOCK_MODE]; // R11
	assign powerUp = q.regs.ctl[vac_pkg::CTL_POWER_UP]; // R12
	assign offsetDacCode = q.regs.ofs; // R14
	assign gainCode = q.regs.gain; // R15
	assign dataValid = q.valid;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	soft_reset_force_a: assert property (@(posedge mclk) disable iff (!rstn) // R4
		!q.regs.ctl[7] |-> (q.regs.ofs == 8'h80) && (q.regs.gain == 6'h00)
		&& (q.regs.smp == 8'h00) && (q.regs.ctl[6:0] == 7'h00))
		else $error("registers not forced while soft reset is low");

	locked_write_a: assert property (@(posedge mclk) disable iff (!rstn) // R5
		(commit && !q.regs.ctl[7] && (wrAddr != 3'h0)) |=> $stable(q.regs))
		else $error("write accepted while soft reset is low");

	short_frame_a: assert property (@(posedge mclk) disable iff (!rstn) // R21
		(enRise && (q.bitCnt != 5'h10)) |=> $stable(q.regs))
		else $error("short frame changed a register");

	lane_release_a: assert property (@(posedge mclk) disable iff (!rstn) // R22
		(!enLowSync) [*2] |-> !laneOe)
		else $error("lanes driven while serial enable is low");

	pdown_halt_a: assert property (@(posedge mclk) disable iff (!rstn) // R12
		!powerUp |=> !dataLevelSamplePulse && !feedthroughSamplePulse && !dataValid)
		else $error("pulse logic running in power-down");

	pdown_retain_a: assert property (@(posedge mclk) disable iff (!rstn) // R13
		(!powerUp && !commit) |=> $stable(q.regs))
		else $error("register changed in power-down without a write");

	feed_mode_only_a: assert property (@(posedge mclk) disable iff (!rstn) // R10
		!correlatedSamplingMode |=> !feedthroughSamplePulse)
		else $error("feed-through pulse outside correlated mode");

	trig_source_a: assert property (@(posedge mclk) disable iff (!rstn) // R16
		(powerUp && q.regs.smp[5]) |=> (dataLevelSamplePulse == $past(trigSync)))
		else $error("data pulse does not follow external trigger");

	settle_hold_a: assert property (@(posedge mclk) disable iff (!rstn) // R1
		(d.regs != q.regs) |=> !dataValid [*8])
		else $error("data valid too soon after register change");

	settle_bound_a: assert property (@(posedge mclk) disable iff (!rstn) // R1
		((q.settle == '0) && powerUp && (d.regs == q.regs)) |=> dataValid)
		else $error("data not valid after settle period");

	settle_range_a: assert property (@(posedge mclk) disable iff (!rstn) // R1
		q.settle <= SETTLE_CYCLES[vac_pkg::SETTLE_W-1:0])
		else $error("settle counter out of range");

	data_fall_a: assert property (@(posedge mclk) disable iff (!rstn) // R17
		(powerUp && !q.regs.smp[5] && (q.slot == 3'h7)) |=> !dataLevelSamplePulse)
		else $error("data pulse falling edge moved");

	data_rise_a: assert property (@(posedge mclk) disable iff (!rstn) // R17
		(powerUp && !q.regs.smp[5] && (q.slot == 3'h6)) |=> dataLevelSamplePulse)
		else $error("data pulse missing before its fixed fall");

	lane_drive_a: assert property (@(posedge mclk) disable iff (!rstn) // R22
		(enLowSync) [*2] |-> laneOe)
		else $error("lanes not driven while serial enable is high");

	turn_quiet_a: assert property (@(posedge mclk) disable iff (!rstn) // R22
		(q.laneOe || (q.turnCnt != 2'h0)) |=> $stable(q.shift))
		else $error("link bit taken while lanes turn round");

endmodule
`default_nettype wire

// ===== rtl/vac_pkg.sv
`default_nettype none
package vac_pkg;

	// ------------------------------------------------------------
	// Register addresses (3-bit address field of a write frame)
	// ------------------------------------------------------------
	localparam logic [2:0] ADDR_OPERATING_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_OFFSET_DAC_CODE = 3'h1;
	localparam logic [2:0] ADDR_GAIN_CODE = 3'h2;
	localparam logic [2:0] ADDR_SAMPLING_OUTPUT_CONTROL = 3'h3;
	localparam logic [2:0] ADDR_FACTORY_TEST_A = 3'h4;
	localparam logic [2:0] ADDR_FACTORY_TEST_B = 3'h5;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_OPERATING_CONTROL = 8'h00;
	localparam logic [7:0] RST_OFFSET_DAC_CODE = 8'h80;
	localparam logic [5:0] RST_GAIN_CODE = 6'h00;
	localparam logic [7:0] RST_SAMPLING_OUTPUT_CONTROL = 8'h00;

	// ------------------------------------------------------------
	// Field positions and write masks
	// ------------------------------------------------------------
	localparam int CTL_SOFT_RESET = 7;
	localparam int CTL_DRIVE_DOUBLE = 5;
	localparam int CTL_INPUT_MODE = 4;
	localparam int CTL_FEED_POS_LSB = 2;
	localparam int CTL_CLOCK_MODE = 1;
	localparam int CTL_POWER_UP = 0;
	localparam logic [7:0] CTL_WRITE_MASK = 8'hBF;
	localparam logic [7:0] SMP_WRITE_MASK = 8'h39;
	localparam int SMP_SOURCE_EXT = 5;
	localparam int SMP_WIDTH_LSB = 3;
	localparam int SMP_SPLIT_ORDER = 0;
	localparam int FRAME_ADDR_LSB = 8;

	// ------------------------------------------------------------
	// Frame, pixel and timing constants
	// ------------------------------------------------------------
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [2:0] LAST_SLOT = 3'h7;
	localparam logic [2:0] FEED_BASE_SLOT = 3'h1;
	localparam logic [1:0] TURN_CYCLES = 2'h2;
	localparam int SETTLE_MS = 10;
	localparam int CLK_MHZ = 250;
	localparam int SETTLE_CYCLES = SETTLE_MS * CLK_MHZ * 1000;
	localparam int SETTLE_W = 24;

	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] ofs;
		logic [5:0] gain;
		logic [7:0] smp;
	} vac_regs_t;

	typedef struct packed {
		vac_regs_t regs;
		logic [15:0] shift;
		logic [4:0] bitCnt;
		logic sclkPrev;
		logic enPrev;
		logic [SETTLE_W-1:0] settle;
		logic [2:0] slot;
		logic [15:0] capture;
		logic dataPulse;
		logic feedPulse;
		logic [1:0] lane;
		logic [1:0] turnCnt;
		logic laneOe;
		logic valid;
	} vac_state_t;

endpackage
`default_nettype wire

// ===== rtl/vac_sync.sv
`default_nettype none
module vac_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} vac_sync_state_t;

	vac_sync_state_t q;
	vac_sync_state_t d;

	// First stage is read only by the second stage
	always_comb begin
		d.meta = asyncIn;
		d.stable = q.meta;
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			q <= {RESET_VAL, RESET_VAL};
		end else begin
			q <= d;
		end
	end

	assign syncOut = q.stable;

endmodule
`default_nettype wire

// ===== bench/vac_host_model.sv
`default_nettype none
module vac_host_model (
	output logic serialEnableLow,
	output logic linkClk,
	output logic linkData,
	output logic hostOe
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		serialEnableLow = 1'b1;
		linkClk = 1'b0;
		linkData = 1'b0;
		hostOe = 1'b0;
	end

	// ------------------------------------------------------------
	// One write frame; extra leading edges carry ones so a device
	// that keeps the first bits instead of the last ones is caught
	// ------------------------------------------------------------
	task automatic sendFrame(input logic [2:0] addr, input logic [7:0] data, input int nEdges);
		logic [19:0] word;
		word = {4'hF, 5'h00, addr, data};
		#1.3;
		serialEnableLow = 1'b0;
		// Wait for the lanes to turn round before driving them
		#40 hostOe = 1'b1;
		for (int i = nEdges - 1; i >= 0; i--) begin
			linkData = word[i];
			#40 linkClk = 1'b1;
			#40 linkClk = 1'b0;
		end
		#40 serialEnableLow = 1'b1;
		hostOe = 1'b0;
		linkData = 1'b0;
		#80;
	endtask
endmodule
`default_nettype wire

// ===== bench/test_vac_control_regs.sv
`default_nettype none
module test_vac_control_regs;
	timeunit 1ns;
	timeprecision 100ps;

	logic mclk, rstn, sampleTriggerIn, enLow, linkClk, linkData, hostOe;
	logic laneZeroOut, laneOneOut, laneOe, dataLevelSamplePulse, feedthroughSamplePulse;
	logic driveDouble, correlatedSamplingMode, doubleEdgeMode, powerUp, dataValid;
	logic laneZeroWire, laneOneWire;
	logic [15:0] convData;
	logic [7:0] offsetDacCode;
	logic [5:0] gainCode;
	int nErrors = 0;
	int checkCount = 0;
	localparam int SETTLE_SIM = 20;

	// Shared pins: device drives when enabled, else host, else pull-down
	assign laneZeroWire = laneOe ? laneZeroOut : (hostOe ? linkClk : 1'b0);
	assign laneOneWire = laneOe ? laneOneOut : (hostOe ? linkData : 1'b0);

	vac_host_model i_vac_host_model (.serialEnableLow(enLow), .linkClk(linkClk),
		.linkData(linkData), .hostOe(hostOe));

	vac_control_regs #(.SETTLE_CYCLES(SETTLE_SIM)) i_vac_control_regs (.mclk(mclk), .rstn(rstn),
		.laneZeroIn(laneZeroWire), .laneOneIn(laneOneWire), .serialEnableLow(enLow),
		.sampleTriggerIn(sampleTriggerIn), .convData(convData), .laneZeroOut(laneZeroOut),
		.laneOneOut(laneOneOut), .laneOe(laneOe), .dataLevelSamplePulse(dataLevelSamplePulse),
		.feedthroughSamplePulse(feedthroughSamplePulse), .driveDouble(driveDouble),
		.correlatedSamplingMode(correlatedSamplingMode), .doubleEdgeMode(doubleEdgeMode),
		.powerUp(powerUp), .offsetDacCode(offsetDacCode), .gainCode(gainCode),
		.dataValid(dataValid));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", checkCount, nErrors);
		if (nErrors == 0 && checkCount > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp) begin
			nErrors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Commit lands a few master cycles after the enable rises
	task automatic wr(input logic [2:0] addr, input logic [7:0] data, input int n = 16);
		i_vac_host_model.sendFrame(addr, data, n);
		cyc(8);
	endtask

	task automatic countPulse(input bit feed, output int c);
		c = 0;
		repeat (16) begin
			@(posedge mclk);
			c += feed ? int'(feedthroughSamplePulse) : int'(dataLevelSamplePulse);
		end
	endtask

	// Cycles until the chosen pulse is seen; a missing pulse ends the run
	task automatic waitPulse(input bit feed, output int n);
		for (n = 0; n < 40
			&& (feed ? feedthroughSamplePulse : dataLevelSamplePulse) !== 1'b1; n++) begin
			cyc(1);
		end
		if (n == 40) begin
			nErrors++;
			$display("mismatch at %0t: sample pulse missing", $time);
			summarize();
		end
	endtask

	// Width code 0 puts the data pulse in the last slot, marking word starts
	task automatic grabWord(input bit split, output logic [15:0] w);
		int n;
		w = 16'h0000;
		waitPulse(1'b0, n);
		repeat (8) begin
			cyc(1);
			if (split) begin
				w = {w[14:8], laneOneOut, w[6:0], laneZeroOut};
			end else begin
				w = {w[13:0], laneOneOut, laneZeroOut};
			end
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic tResetAndGate();
		check(8'(powerUp), 8'h00);
		check(8'(dataValid), 8'h00);
		check(offsetDacCode, 8'h80);
		check(8'(gainCode), 8'h00);
		wr(3'h1, 8'h11);
		check(offsetDacCode, 8'h80);
		wr(3'h0, 8'h80);
		wr(3'h1, 8'h11);
		check(offsetDacCode, 8'h11);
		$display("test reset and gate done");
	endtask

	task automatic tFields();
		wr(3'h0, 8'hB3);
		check(8'(driveDouble), 8'h01);
		check(8'(correlatedSamplingMode), 8'h01);
		check(8'(doubleEdgeMode), 8'h01);
		check(8'(powerUp), 8'h01);
		wr(3'h0, 8'h81);
		check({driveDouble, correlatedSamplingMode, doubleEdgeMode, powerUp}, 8'h01);
		wr(3'h1, 8'hC5);
		wr(3'h2, 8'hFF);
		check(offsetDacCode, 8'hC5);
		check(8'(gainCode), 8'h3F);
		$display("test fields done");
	endtask

	task automatic tFrames();
		wr(3'h1, 8'h3C, 15);
		check(offsetDacCode, 8'hC5);
		fork
			wr(3'h1, 8'h3C, 20);
			begin
				cyc(20);
				check(8'(laneOe), 8'h00);
			end
		join
		check(offsetDacCode, 8'h3C);
		check(8'(laneOe), 8'h01);
		wr(3'h5, 8'hFF);
		check(offsetDacCode, 8'h3C);
		check(8'(gainCode), 8'h3F);
		$display("test frames done");
	endtask

	task automatic tSettlePower();
		int i;
		int n;
		for (i = 0; i < 60 && dataValid !== 1'b1; i++) begin
			cyc(1);
		end
		check(8'(dataValid), 8'h01);
		if (i == 60) begin
			summarize();
		end
		fork
			wr(3'h1, 8'h3D);
			begin
				for (i = 0; i < 600 && dataValid !== 1'b0; i++) begin
					cyc(1);
				end
				check(8'(dataValid), 8'h00);
				if (i == 600) begin
					summarize();
				end
				for (n = 0; n < 40 && dataValid !== 1'b1; n++) begin
					cyc(1);
				end
				check(8'(n), 8'(SETTLE_SIM));
				if (n == 40) begin
					summarize();
				end
			end
		join
		wr(3'h0, 8'h80);
		check(8'(powerUp), 8'h00);
		wr(3'h0, 8'h81);
		check(offsetDacCode, 8'h3D);
		check(8'(gainCode), 8'h3F);
		$display("test settle and power done");
	endtask

	task automatic tPulses();
		int c;
		wr(3'h0, 8'h91);
		countPulse(1'b1, c);
		check(8'(c), 8'h02);
		wr(3'h0, 8'h81);
		countPulse(1'b1, c);
		check(8'(c), 8'h00);
		wr(3'h3, 8'hD8);
		countPulse(1'b0, c);
		check(8'(c), 8'h08);
		wr(3'h3, 8'h00);
		countPulse(1'b0, c);
		check(8'(c), 8'h02);
		wr(3'h3, 8'h38);
		countPulse(1'b0, c);
		check(8'(c), 8'h00);
		sampleTriggerIn <= 1'b1;
		cyc(6);
		check(8'(dataLevelSamplePulse), 8'h01);
		sampleTriggerIn <= 1'b0;
		$display("test pulses done");
	endtask

	task automatic tLanes();
		int n;
		logic [15:0] w;
		wr(3'h3, 8'h00);
		grabWord(1'b0, w);
		check(w[15:8], convData[15:8]);
		check(w[7:0], convData[7:0]);
		wr(3'h3, 8'h01);
		grabWord(1'b1, w);
		check(w[15:8], convData[15:8]);
		check(w[7:0], convData[7:0]);
		wr(3'h0, 8'h9D);
		waitPulse(1'b0, n);
		waitPulse(1'b1, n);
		check(8'(n), 8'h05);
		$display("test lanes and position done");
	endtask

	task automatic tSoftReset();
		wr(3'h0, 8'h00);
		check(offsetDacCode, 8'h80);
		check(8'(gainCode), 8'h00);
		check(8'(dataLevelSamplePulse), 8'h00);
		$display("test soft reset done");
	endtask

	initial begin
		#200us;
		nErrors++;
		$display("mismatch at %0t: run timed out", $time);
		summarize();
	end

	initial begin
		rstn = 1'b0;
		sampleTriggerIn = 1'b0;
		convData = 16'hA5C3;
		cyc(10);
		rstn <= 1'b1;
		cyc(4);
		tResetAndGate();
		tFields();
		tFrames();
		tSettlePower();
		tPulses();
		tLanes();
		tSoftReset();
		summarize();
	end
endmodule
`default_nettype wire
